// >>> logic/mmr_readback.sv
`timescale 1ns/10ps
`include "mmr_defines.svh"
// How it works
// - phase C current raw, scale 2^27, base/8
// - current gain register, 16-bit, 468h, resets zero
// - gain codes 0..3 mean max gain x8..x1
// - voltage gain register, 16-bit, 472h, resets zero
// - voltage codes 0,1,2 mean 60V,30V,15V
// - supply voltage register, 32-bit, 474h, resets zero
// - supply volts equal raw times 60 over 2^27
module mmr_readback (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [13:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       meas_valid,
  input  wire logic [31:0]                meas_phase_c_current,
  input  wire mmr_pkg::mmr_current_gain_t meas_current_gain,
  input  wire mmr_pkg::mmr_voltage_gain_t meas_voltage_gain,
  input  wire logic [31:0]                meas_supply_voltage,
  output logic                            readback_frozen
);

  ////////////////////////////////////////////////////////////////////////////
  // measurement capture

  logic [31:0] third_phase_current_readback_q;
  logic [15:0] current_sense_gain_readback_q;
  logic [15:0] voltage_sense_gain_readback_q;
  logic [31:0] supply_voltage_readback_q;
  logic [15:0] current_gain_wide;
  logic [15:0] voltage_gain_wide;
  logic [31:0] control_q;
  logic [31:0] control_d;
  logic        freeze;
  logic        meas_load;

  assign freeze = control_q[`MMR_CTRL_FREEZE_BIT];

  // one strobe loads all four words, so they always come from one sample
  assign meas_load = meas_valid && !freeze;

  // gain codes are two bits wide; the upper bits of the word read zero
  assign current_gain_wide = {14'h0000, meas_current_gain};
  assign voltage_gain_wide = {14'h0000, meas_voltage_gain};

  // only the measurement side loads these; the bus path never reaches them
  mmr_hold_reg #(
    .WIDTH (32),
    .RESET (`MMR_RST_WORD32)
  ) u_mmr_hold_reg_current (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (meas_load),
    .din     (meas_phase_c_current),
    .dout    (third_phase_current_readback_q)
  );

  mmr_hold_reg #(
    .WIDTH (16),
    .RESET (`MMR_RST_WORD16)
  ) u_mmr_hold_reg_cgain (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (meas_load),
    .din     (current_gain_wide),
    .dout    (current_sense_gain_readback_q)
  );

  mmr_hold_reg #(
    .WIDTH (16),
    .RESET (`MMR_RST_WORD16)
  ) u_mmr_hold_reg_vgain (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (meas_load),
    .din     (voltage_gain_wide),
    .dout    (voltage_sense_gain_readback_q)
  );

  mmr_hold_reg #(
    .WIDTH (32),
    .RESET (`MMR_RST_WORD32)
  ) u_mmr_hold_reg_supply (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (meas_load),
    .din     (meas_supply_voltage),
    .dout    (supply_voltage_readback_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        frozen_q;
  logic        frozen_d;
  logic        hit;
  logic [31:0] rdata;
  logic        access;
  logic        commit;
  logic        sel_current;
  logic        sel_cgain;
  logic        sel_vgain;
  logic        sel_supply;
  logic        sel_control;
  logic        ctrl_write;

  assign access = psel && penable;
  assign commit = access && pready_q;

  // one select per mapped word; at most one is high at a time
  assign sel_current = (paddr == `MMR_ADDR_PHASE_C_CURRENT);
  assign sel_cgain   = (paddr == `MMR_ADDR_CURRENT_GAIN);
  assign sel_vgain   = (paddr == `MMR_ADDR_VOLTAGE_GAIN);
  assign sel_supply  = (paddr == `MMR_ADDR_SUPPLY_VOLTAGE);
  assign sel_control = (paddr == `MMR_ADDR_CONTROL);
  assign hit         = sel_current || sel_cgain || sel_vgain || sel_supply || sel_control;

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (sel_current) begin
      rdata = third_phase_current_readback_q;
    end
    if (sel_cgain) begin
      rdata = {16'h0000, current_sense_gain_readback_q};
    end
    if (sel_vgain) begin
      rdata = {16'h0000, voltage_sense_gain_readback_q};
    end
    if (sel_supply) begin
      rdata = supply_voltage_readback_q;
    end
    if (sel_control) begin
      rdata = control_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one pulse per transfer, data zero outside it

  always_comb begin
    pready_d  = 1'b0;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (access && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !hit;
      prdata_d  = pwrite ? 32'h0000_0000 : rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control word: the only writable one

  // writes to the readback words complete okay and are dropped here
  assign ctrl_write = commit && pwrite && sel_control && pstrb[0];

  always_comb begin
    control_d = control_q;
    if (ctrl_write) begin
      control_d = {31'h0000_0000, pwdata[`MMR_CTRL_FREEZE_BIT]};
    end
    frozen_d = control_d[`MMR_CTRL_FREEZE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `MMR_RST_CONTROL;
      frozen_q  <= 1'b0;
    end else begin
      control_q <= control_d;
      frozen_q  <= frozen_d;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign readback_frozen = frozen_q;

endmodule // mmr_readback

////////////////////////////////////////////////////////////////////////////
// hold register: loads on a strobe, otherwise keeps its word

module mmr_hold_reg #(
  parameter int               WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] word_q;
  logic [WIDTH-1:0] word_d;

  always_comb begin
    word_d = word_q;
    if (load) begin
      word_d = din;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= RESET;
    end else begin
      word_q <= word_d;
    end
  end

  assign dout = word_q;

endmodule // mmr_hold_reg

// >>> logic/mmr_defines.svh
`ifndef MMR_DEFINES_SVH
`define MMR_DEFINES_SVH

// register indices as printed; the byte address is four times the index
`define MMR_IDX_PHASE_C_CURRENT   12'h444
`define MMR_IDX_CURRENT_GAIN      12'h468
`define MMR_IDX_VOLTAGE_GAIN      12'h472
`define MMR_IDX_SUPPLY_VOLTAGE    12'h474
`define MMR_IDX_CONTROL           12'h480

// byte addresses seen on paddr
`define MMR_ADDR_PHASE_C_CURRENT  14'h1110
`define MMR_ADDR_CURRENT_GAIN     14'h11A0
`define MMR_ADDR_VOLTAGE_GAIN     14'h11C8
`define MMR_ADDR_SUPPLY_VOLTAGE   14'h11D0
`define MMR_ADDR_CONTROL          14'h1200

// reset values
`define MMR_RST_WORD32            32'h0000_0000
`define MMR_RST_WORD16            16'h0000
`define MMR_RST_CONTROL           32'h0000_0000

// field positions
`define MMR_GAIN_CODE_MSB         1
`define MMR_GAIN_CODE_LSB         0
`define MMR_CTRL_FREEZE_BIT       0

// fixed-point scaling: value = raw / 2^27 times a full-scale figure
`define MMR_SCALE_FRAC_BITS       27
`define MMR_SUPPLY_FULL_SCALE_V   60

`endif

// >>> logic/mmr_pkg.sv
package mmr_pkg;

  // current-sense gain code: multiple of the maximum amplifier gain
  typedef enum logic [1:0] {
    MMR_CSG_X8 = 2'h0,
    MMR_CSG_X4 = 2'h1,
    MMR_CSG_X2 = 2'h2,
    MMR_CSG_X1 = 2'h3
  } mmr_current_gain_t;

  // voltage-sense gain code: full-scale range
  typedef enum logic [1:0] {
    MMR_VSG_60V  = 2'h0,
    MMR_VSG_30V  = 2'h1,
    MMR_VSG_15V  = 2'h2,
    MMR_VSG_RSVD = 2'h3
  } mmr_voltage_gain_t;

endpackage : mmr_pkg

// >>> testbench/mmr_readback_checker.sv
`timescale 1ns/10ps
`include "mmr_defines.svh"
module mmr_readback_checker (
  input wire logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic                       meas_valid, readback_frozen,
  input wire logic [13:0]                paddr,
  input wire logic [31:0]                pwdata, prdata, meas_phase_c_current, meas_supply_voltage,
  input wire logic [3:0]                 pstrb,
  input wire mmr_pkg::mmr_current_gain_t meas_current_gain,
  input wire mmr_pkg::mmr_voltage_gain_t meas_voltage_gain
);
  logic [67:0] sh_q;
  logic        rd;
  // shadow of the last measurement the block should have taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_q <= '0;
    else if (meas_valid && !readback_frozen)
      sh_q <= {meas_phase_c_current, meas_supply_voltage, meas_current_gain, meas_voltage_gain};
  end
  assign rd = pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pulse");
  a_addr_decode: assert property (pready |-> pslverr == !(paddr inside {`MMR_ADDR_PHASE_C_CURRENT,
    `MMR_ADDR_CURRENT_GAIN, `MMR_ADDR_VOLTAGE_GAIN, `MMR_ADDR_SUPPLY_VOLTAGE, `MMR_ADDR_CONTROL})) else $error("dec");
  a_read_current: assert property (rd && paddr == `MMR_ADDR_PHASE_C_CURRENT |-> prdata == $past(sh_q[67:36]))
    else $error("cur");
  a_read_cgain: assert property (rd && paddr == `MMR_ADDR_CURRENT_GAIN |-> prdata == {30'h0, $past(sh_q[3:2])})
    else $error("cg");
  a_read_vgain: assert property (rd && paddr == `MMR_ADDR_VOLTAGE_GAIN |-> prdata == {30'h0, $past(sh_q[1:0])})
    else $error("vg");
  a_read_supply: assert property (rd && paddr == `MMR_ADDR_SUPPLY_VOLTAGE |-> prdata == $past(sh_q[35:4]))
    else $error("sup");
  a_write_okay: assert property (pready && pwrite && paddr == `MMR_ADDR_SUPPLY_VOLTAGE |-> !pslverr) else $error("wr");
  c_write: cover property (pready && pwrite);
  c_err: cover property (pready && pslverr);
  c_frozen: cover property (meas_valid && readback_frozen);
endmodule // mmr_readback_checker
bind mmr_readback mmr_readback_checker u_mmr_readback_checker (.*);

// >>> testbench/tb.sv
`timescale 1ns/10ps
`include "mmr_defines.svh"
module tb;
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_valid, readback_frozen, e;
  logic [13:0]                paddr;
  logic [31:0]                pwdata, prdata, meas_phase_c_current, meas_supply_voltage, r;
  logic [3:0]                 pstrb;
  mmr_pkg::mmr_current_gain_t meas_current_gain;
  mmr_pkg::mmr_voltage_gain_t meas_voltage_gain;
  int                         err_count, total_checks;
  // row: phase c current, supply, current gain code, voltage gain code
  logic [31:0] rows [4][4] = '{'{32'h0800_0000, 32'h0800_0000, 32'h0, 32'h0}, '{32'hFFFF_FFFF, 32'h0400_0000, 32'h1, 32'h1},
                               '{32'h0000_0001, 32'hFFFF_FFFF, 32'h2, 32'h2}, '{32'h8000_0000, 32'h0000_0001, 32'h3, 32'h3}};
  mmr_readback u_mmr_readback (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic ld(input logic [31:0] c, s, input logic [1:0] g, v);
    @(posedge pclk);
    {meas_valid, meas_phase_c_current, meas_supply_voltage} <= {1'b1, c, s};
    meas_current_gain <= mmr_pkg::mmr_current_gain_t'(g);
    meas_voltage_gain <= mmr_pkg::mmr_voltage_gain_t'(v);
    @(posedge pclk);
    meas_valid <= 1'b0;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, meas_valid, paddr, pwdata, meas_phase_c_current, meas_supply_voltage} = '0;
    pstrb = 4'hF;
    meas_current_gain = mmr_pkg::MMR_CSG_X8;
    meas_voltage_gain = mmr_pkg::MMR_VSG_60V;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ld(rows[i][0], rows[i][1], rows[i][2][1:0], rows[i][3][1:0]);
      rd(`MMR_ADDR_PHASE_C_CURRENT, rows[i][0]);
      rd(`MMR_ADDR_CURRENT_GAIN, rows[i][2]);
      rd(`MMR_ADDR_VOLTAGE_GAIN, rows[i][3]);
      rd(`MMR_ADDR_SUPPLY_VOLTAGE, rows[i][1]);
      $display("row %0d done", i);
    end
    apb(1'b1, `MMR_ADDR_SUPPLY_VOLTAGE, 32'h1234_5678);
    chk({31'h0, e}, 32'h0);
    rd(`MMR_ADDR_SUPPLY_VOLTAGE, rows[3][1]);
    rd(14'h0004, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `MMR_ADDR_CONTROL, 32'h1);
    ld(32'h5555_5555, 32'h5555_5555, 2'h1, 2'h1);
    rd(`MMR_ADDR_PHASE_C_CURRENT, rows[3][0]);
    chk({31'h0, readback_frozen}, 32'h1);
    $display("write, decode and freeze done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MMR_ADDR_PHASE_C_CURRENT, 32'h0);
    rd(`MMR_ADDR_CURRENT_GAIN, 32'h0);
    rd(`MMR_ADDR_VOLTAGE_GAIN, 32'h0);
    rd(`MMR_ADDR_SUPPLY_VOLTAGE, 32'h0);
    chk({31'h0, readback_frozen}, 32'h0);
    $display("reset done");
    wrap_up();
  end
endmodule // tb
